/* src/ctp_consts.vh */
// Constants for the character translation and parity stage
`ifndef CTP_CONSTS_VH
`define CTP_CONSTS_VH

// Character codes
`define CTP_HOST_LINE_END_CODE 8'h9B
`define CTP_CR_CODE 8'h0D
`define CTP_LF_CODE 8'h0A
`define CTP_LOW_LIMIT 8'h20
`define CTP_HIGH_LIMIT 8'h7C

// Fields of the translation option word
`define CTP_TX_PAR_LSB 0
`define CTP_RX_PAR_LSB 2
`define CTP_XLAT_LSB 4
`define CTP_APPEND_LF_BIT 6
`define CTP_OPT_WIDTH 7

// Translation selections
`define CTP_XLAT_LIGHT 2'h0
`define CTP_XLAT_HEAVY 2'h1
`define CTP_XLAT_NONE 2'h2

// Transmit parity settings
`define CTP_TXP_KEEP 2'h0
`define CTP_TXP_ODD 2'h1
`define CTP_TXP_EVEN 2'h2
`define CTP_TXP_ONE 2'h3

// Receive parity settings
`define CTP_RXP_KEEP 2'h0
`define CTP_RXP_ODD 2'h1
`define CTP_RXP_EVEN 2'h2
`define CTP_RXP_CLEAR 2'h3

// Word sizes on the line
`define CTP_WS_8 2'h0
`define CTP_WS_7 2'h1
`define CTP_WS_6 2'h2
`define CTP_WS_5 2'h3

// Reset values of the configuration
`define CTP_OPT_RESET 7'h00
`define CTP_SUBST_RESET 8'h00
`define CTP_WS_RESET 2'h0

// Transmit buffer depth
`define CTP_FIFO_DEPTH 32

`endif

/* src/ctp_fifo.v */
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module ctp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32
) (
    input wire clk_i,
    input wire rst_b_i,
    input wire ce_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam [AW:0] FULL_COUNT = DEPTH[AW:0];

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;

    assign in_ready_o = (count != FULL_COUNT);
    assign out_valid_o = (count != {(AW+1){1'b0}});
    assign out_data_o = mem[rd_ptr];
    assign push = ce_i & in_valid_i & in_ready_o;
    assign pop = ce_i & out_valid_o & out_ready_i;

    function [AW-1:0] ctp_bump;
        input [AW-1:0] p;
        begin
            if (p == DEPTH - 1) begin
                ctp_bump = {AW{1'b0}};
            end else begin
                ctp_bump = p + 1'b1;
            end
        end
    endfunction

    always @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= ctp_bump(wr_ptr);
            end
            if (pop) begin
                rd_ptr <= ctp_bump(rd_ptr);
            end
            if (push & !pop) begin
                count <= count + 1'b1;
            end else if (pop & !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

/* src/ctp_rx_path.v */
// Receive path: widening, parity check and translation into a register stage
`timescale 1ns/1ps
`include "ctp_consts.vh"
module ctp_rx_path (
    input wire clk_i,
    input wire rst_b_i,
    input wire ce_i,
    input wire [1:0] xlat_i,
    input wire [1:0] par_mode_i,
    input wire [1:0] word_size_i,
    input wire [7:0] subst_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [7:0] in_data_i,
    output reg out_valid_o,
    input wire out_ready_i,
    output reg [7:0] out_data_o,
    output reg par_err_o
);
    reg [7:0] wide;
    reg [7:0] checked;
    reg [7:0] xlat;
    reg mismatch;
    wire take;

    assign in_ready_o = !out_valid_o | out_ready_i;
    assign take = ce_i & in_valid_i & in_ready_o;

    always @* begin
        // Short words come in with the missing high bits set
        case (word_size_i)
            `CTP_WS_7: wide = {1'b1, in_data_i[6:0]};
            `CTP_WS_6: wide = {2'b11, in_data_i[5:0]};
            `CTP_WS_5: wide = {3'b111, in_data_i[4:0]};
            default: wide = in_data_i;
        endcase
        mismatch = 1'b0;
        checked = {1'b0, wide[6:0]};
        case (par_mode_i)
            `CTP_RXP_ODD: mismatch = ~(^wide);
            `CTP_RXP_EVEN: mismatch = ^wide;
            `CTP_RXP_CLEAR: mismatch = 1'b0;
            default: checked = wide;
        endcase
        xlat = checked;
        if (xlat_i != `CTP_XLAT_NONE) begin
            xlat = {1'b0, checked[6:0]};
            if (xlat == `CTP_CR_CODE) begin
                xlat = `CTP_HOST_LINE_END_CODE;
            end else if ((xlat_i == `CTP_XLAT_HEAVY) &&
                         ((xlat < `CTP_LOW_LIMIT) || (xlat > `CTP_HIGH_LIMIT))) begin
                xlat = subst_i;
            end
        end
    end

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            out_valid_o <= 1'b0;
            out_data_o <= 8'h00;
            par_err_o <= 1'b0;
        end else if (ce_i) begin
            par_err_o <= take & mismatch;
            if (take) begin
                out_valid_o <= 1'b1;
                out_data_o <= xlat;
            end else if (out_ready_i) begin
                out_valid_o <= 1'b0;
            end
        end
    end
endmodule

/* src/ctp_top.v */
// Character translation and parity stage between host stream and line framer
`timescale 1ns/1ps
`include "ctp_consts.vh"
// Overview of operation
// - One selection governs both directions
// - No translation passes characters unchanged
// - Line-end becomes CR out, CR line-end in
// - Append-LF turns line-end into CR, LF
// - Translation clears top bit both ways
// - Light mode only clears bit, swaps codes
// - Reset selects light translation
// - Heavy receive substitutes codes outside 32..124
// - Substitute character programmable, resets to zero
// - Heavy transmit drops controls, high, top-bit codes
// - No LF appended without translation
// - Both CR and LF get parity, shortening
// - Reset disables append-LF
// - Separate receive and transmit parity settings
// - Parity lives in bit 7
// - Reset leaves parity bit untouched
// - Transmit parity keep, odd, even, one
// - Receive parity keep, odd, even, clear
// - Mismatch delivers character, sets sticky flag
// - Stage order fixed in each direction
// - Transmit parity code 0..3 in word
// - Receive parity code weights 4, 8, 12
// - Append-LF weight 64 in option word
module ctp_top #(
    parameter FIFO_DEPTH = `CTP_FIFO_DEPTH
) (
    input wire clk_i,
    input wire rst_b_i,
    input wire ce_i,
    input wire cfg_load_i,
    input wire [6:0] translation_option_word_i,
    input wire [7:0] substitute_char_value_i,
    input wire [1:0] word_size_i,
    input wire tx_host_valid_i,
    output wire tx_host_ready_o,
    input wire [7:0] tx_host_data_i,
    output wire tx_line_valid_o,
    input wire tx_line_ready_i,
    output wire [7:0] tx_line_data_o,
    input wire rx_line_valid_i,
    output wire rx_line_ready_o,
    input wire [7:0] rx_line_data_i,
    output wire rx_host_valid_o,
    input wire rx_host_ready_i,
    output wire [7:0] rx_host_data_o,
    input wire par_err_clr_i,
    output reg par_err_o,
    output wire [1:0] xlat_mode_o,
    output wire append_lf_o
);
    // Transmit sequencing states
    localparam [1:0] ST_PASS = 2'b01;
    localparam [1:0] ST_LF = 2'b10;

    // Configuration held until the next load; kept across traffic
    reg [`CTP_OPT_WIDTH-1:0] opt_word;
    reg [7:0] subst_char;
    reg [1:0] word_size;
    reg [1:0] state;
    reg [1:0] next_state;

    wire [1:0] xlat_sel;
    wire [1:0] tx_par;
    wire [1:0] rx_par;
    wire append_lf;

    reg [7:0] tx_xlat;
    reg tx_drop;
    reg tx_want_lf;
    reg [7:0] fifo_char;
    reg fifo_push;
    wire fifo_in_ready;
    wire [7:0] fifo_in_data;
    wire tx_take;
    wire rx_par_err;

    // Parity generation on bit 7, then shortening to the line word size
    function [7:0] ctp_tx_finish;
        input [7:0] c;
        input [1:0] mode;
        input [1:0] ws;
        reg [7:0] p;
        begin
            p = c;
            case (mode)
                `CTP_TXP_ODD: p = {~(^c[6:0]), c[6:0]};
                `CTP_TXP_EVEN: p = {^c[6:0], c[6:0]};
                `CTP_TXP_ONE: p = {1'b1, c[6:0]};
                default: p = c;
            endcase
            // Bits above a short word are zeroed; the framer sends only the low bits
            case (ws)
                `CTP_WS_7: ctp_tx_finish = {1'b0, p[6:0]};
                `CTP_WS_6: ctp_tx_finish = {2'b00, p[5:0]};
                `CTP_WS_5: ctp_tx_finish = {3'b000, p[4:0]};
                default: ctp_tx_finish = p;
            endcase
        end
    endfunction

    assign xlat_sel = (opt_word[`CTP_XLAT_LSB+1:`CTP_XLAT_LSB] == `CTP_XLAT_HEAVY) ? `CTP_XLAT_HEAVY :
                      (opt_word[`CTP_XLAT_LSB+1:`CTP_XLAT_LSB] == `CTP_XLAT_LIGHT) ? `CTP_XLAT_LIGHT :
                      `CTP_XLAT_NONE;
    assign tx_par = opt_word[`CTP_TX_PAR_LSB+1:`CTP_TX_PAR_LSB];
    assign rx_par = opt_word[`CTP_RX_PAR_LSB+1:`CTP_RX_PAR_LSB];
    assign append_lf = opt_word[`CTP_APPEND_LF_BIT] & (xlat_sel != `CTP_XLAT_NONE);
    assign xlat_mode_o = xlat_sel;
    assign append_lf_o = append_lf;

    // Configuration registers
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            opt_word <= `CTP_OPT_RESET;
            subst_char <= `CTP_SUBST_RESET;
            word_size <= `CTP_WS_RESET;
        end else if (ce_i & cfg_load_i) begin
            opt_word <= translation_option_word_i;
            subst_char <= substitute_char_value_i;
            word_size <= word_size_i;
        end
    end

    // Transmit translation of the offered character
    always @* begin
        tx_xlat = tx_host_data_i;
        tx_drop = 1'b0;
        tx_want_lf = 1'b0;
        if (xlat_sel != `CTP_XLAT_NONE) begin
            if (tx_host_data_i == `CTP_HOST_LINE_END_CODE) begin
                tx_xlat = `CTP_CR_CODE;
                tx_want_lf = append_lf;
            end else begin
                // Light mode leaves the low seven bits alone
                tx_xlat = {1'b0, tx_host_data_i[6:0]};
                if (xlat_sel == `CTP_XLAT_HEAVY) begin
                    tx_drop = tx_host_data_i[7] ||
                              (tx_host_data_i < `CTP_LOW_LIMIT) ||
                              (tx_host_data_i > `CTP_HIGH_LIMIT);
                end
            end
        end
    end

    assign tx_host_ready_o = state[0] & fifo_in_ready;
    assign tx_take = ce_i & tx_host_valid_i & tx_host_ready_o;

    // What goes into the buffer this cycle, and the next sequencing state
    always @* begin
        next_state = state;
        fifo_push = 1'b0;
        fifo_char = tx_xlat;
        case (state)
            ST_PASS: begin
                if (tx_take) begin
                    fifo_push = !tx_drop;
                    if (tx_want_lf) begin
                        next_state = ST_LF;
                    end
                end
            end
            ST_LF: begin
                fifo_char = `CTP_LF_CODE;
                fifo_push = 1'b1;
                if (fifo_in_ready) begin
                    next_state = ST_PASS;
                end
            end
            default: begin
                next_state = ST_PASS;
            end
        endcase
    end

    // Each character, CR and LF alike, passes parity then shortening
    assign fifo_in_data = ctp_tx_finish(fifo_char, tx_par, word_size);

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= ST_PASS;
        end else if (ce_i) begin
            state <= next_state;
        end
    end

    // Transmit buffer toward the framer; a stalled framer backs up the host
    ctp_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .in_valid_i(fifo_push),
        .in_ready_o(fifo_in_ready),
        .in_data_i(fifo_in_data),
        .out_valid_o(tx_line_valid_o),
        .out_ready_i(tx_line_ready_i),
        .out_data_o(tx_line_data_o)
    );

    // Receive path
    ctp_rx_path u_rx (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .xlat_i(xlat_sel),
        .par_mode_i(rx_par),
        .word_size_i(word_size),
        .subst_i(subst_char),
        .in_valid_i(rx_line_valid_i),
        .in_ready_o(rx_line_ready_o),
        .in_data_i(rx_line_data_i),
        .out_valid_o(rx_host_valid_o),
        .out_ready_i(rx_host_ready_i),
        .out_data_o(rx_host_data_o),
        .par_err_o(rx_par_err)
    );

    // Sticky parity error; a new error wins over a clear in the same cycle
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            par_err_o <= 1'b0;
        end else if (ce_i) begin
            if (rx_par_err) begin
                par_err_o <= 1'b1;
            end else if (par_err_clr_i) begin
                par_err_o <= 1'b0;
            end
        end
    end
endmodule

/* tb/ctp_monitor.sv */
// Port checker for the translation and parity stage
`timescale 1ns/1ps
module ctp_monitor (
    input wire clk_i,
    input wire rst_b_i,
    input wire ce_i,
    input wire cfg_load_i,
    input wire [6:0] translation_option_word_i,
    input wire tx_host_valid_i,
    input wire tx_host_ready_o,
    input wire [7:0] tx_host_data_i,
    input wire tx_line_valid_o,
    input wire tx_line_ready_i,
    input wire [7:0] tx_line_data_o,
    input wire rx_line_valid_i,
    input wire rx_line_ready_o,
    input wire rx_host_valid_o,
    input wire rx_host_ready_i,
    input wire [7:0] rx_host_data_o,
    input wire par_err_clr_i,
    input wire par_err_o,
    input wire [1:0] xlat_mode_o,
    input wire append_lf_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    sequence s_tx_take;
        ce_i && tx_host_valid_i && tx_host_ready_o;
    endsequence
    sequence s_rx_take;
        ce_i && rx_line_valid_i && rx_line_ready_o;
    endsequence
    chk_rx_ready_rule: assert property (rx_line_ready_o == (!rx_host_valid_o || rx_host_ready_i))
        else $error("rx line ready disagrees with host side");
    chk_rx_answer: assert property (s_rx_take |=> rx_host_valid_o)
        else $error("taken word not presented");
    chk_rx_hold: assert property (rx_host_valid_o && !rx_host_ready_i |=>
        rx_host_valid_o && $stable(rx_host_data_o))
        else $error("rx word dropped while stalled");
    chk_tx_hold: assert property (tx_line_valid_o && !tx_line_ready_i |=>
        tx_line_valid_o && $stable(tx_line_data_o))
        else $error("tx word dropped while stalled");
    chk_lf_one_beat: assert property (s_tx_take ##0 (tx_host_data_i == 8'h9B && append_lf_o) |=>
        !tx_host_ready_o)
        else $error("no stall for appended LF");
    chk_none_push: assert property (s_tx_take ##0 xlat_mode_o == 2'h2 |=> tx_line_valid_o)
        else $error("untranslated char not queued");
    chk_heavy_drop: assert property (s_tx_take ##0 (xlat_mode_o == 2'h1 && !tx_line_valid_o &&
        tx_host_data_i != 8'h9B && (tx_host_data_i < 8'h20 || tx_host_data_i > 8'h7C)) |=> !tx_line_valid_o)
        else $error("heavy mode sent an unmapped char");
    // Only line-end may carry the top bit in light mode; heavy substitutes are free 8-bit values
    chk_rx_top_clear: assert property (s_rx_take ##0 xlat_mode_o == 2'h0 |=>
        !rx_host_data_o[7] || rx_host_data_o == 8'h9B)
        else $error("top bit left set");
    chk_flag_sticky: assert property (par_err_o && !par_err_clr_i |=> par_err_o)
        else $error("error flag fell without clear");
    chk_flag_cause: assert property ($rose(par_err_o) |-> $past(rx_line_valid_i && rx_line_ready_o, 2))
        else $error("error flag without a taken word");
    chk_cfg_answer: assert property (ce_i && cfg_load_i |=>
        xlat_mode_o == ($past(translation_option_word_i[5]) ? 2'h2 : {1'b0, $past(translation_option_word_i[4])})
        && append_lf_o == ($past(translation_option_word_i[6]) && !$past(translation_option_word_i[5])))
        else $error("mode outputs disagree with loaded word");
endmodule
bind ctp_top ctp_monitor u_monitor (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .cfg_load_i(cfg_load_i),
    .translation_option_word_i(translation_option_word_i),
    .tx_host_valid_i(tx_host_valid_i),
    .tx_host_ready_o(tx_host_ready_o),
    .tx_host_data_i(tx_host_data_i),
    .tx_line_valid_o(tx_line_valid_o),
    .tx_line_ready_i(tx_line_ready_i),
    .tx_line_data_o(tx_line_data_o),
    .rx_line_valid_i(rx_line_valid_i),
    .rx_line_ready_o(rx_line_ready_o),
    .rx_host_valid_o(rx_host_valid_o),
    .rx_host_ready_i(rx_host_ready_i),
    .rx_host_data_o(rx_host_data_o),
    .par_err_clr_i(par_err_clr_i),
    .par_err_o(par_err_o),
    .xlat_mode_o(xlat_mode_o),
    .append_lf_o(append_lf_o)
);

/* tb/ctp_partner.sv */
// Line framer sink model on the transmit side
`timescale 1ns/1ps
module ctp_partner (
    input wire clk_i,
    input wire [1:0] stall_i,
    input wire valid_i,
    input wire [7:0] data_i,
    output reg ready_o,
    output reg got_o,
    output reg [7:0] got_data_o
);
    initial begin
        ready_o = 1'b1;
        got_o = 1'b0;
        got_data_o = 8'h00;
    end
    // Ready moves only after the falling edge, never near the sampling edge
    always @(negedge clk_i) ready_o <= stall_i == 2'h0 || (stall_i == 2'h1 && $urandom_range(1) != 0);
    always @(posedge clk_i) begin
        got_o <= valid_i && ready_o;
        got_data_o <= data_i;
    end
endmodule

/* tb/testbench.sv */
// Self-checking bench for the translation and parity stage
`timescale 1ns/1ps
`include "ctp_consts.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module testbench;
    reg clk_i = 1'b0;
    reg rst_b_i = 1'b0;
    reg ce_i = 1'b1;
    reg cfg_load_i = 1'b0;
    reg [6:0] translation_option_word_i = 7'h00;
    reg [7:0] substitute_char_value_i = 8'h00;
    reg [1:0] word_size_i = 2'h0;
    reg tx_host_valid_i = 1'b0;
    reg [7:0] tx_host_data_i = 8'h00;
    reg rx_line_valid_i = 1'b0;
    reg [7:0] rx_line_data_i = 8'h00;
    reg rx_host_ready_i = 1'b1;
    reg par_err_clr_i = 1'b0;
    reg [1:0] stall = 2'h0;
    wire tx_host_ready_o, tx_line_valid_o, tx_line_ready_i, rx_line_ready_o, rx_host_valid_o, par_err_o, append_lf_o;
    wire [7:0] tx_line_data_o, rx_host_data_o, got_data;
    wire [1:0] xlat_mode_o;
    wire got;
    reg [8:0] exp_tx[$];
    reg [8:0] exp_rx[$];
    reg [8:0] e;
    reg exp_perr = 1'b0;
    reg [7:0] picks [0:5] = '{8'h9B, 8'h0D, 8'h1F, 8'h20, 8'h7C, 8'h7D};
    int err_count = 0;
    int n_compared = 0;
    int i, a, b;
    // Shallow buffer so that filling it until refusal stays short
    ctp_top #(.FIFO_DEPTH(4)) dut (.*);
    ctp_partner u_partner (.clk_i(clk_i), .stall_i(stall), .valid_i(tx_line_valid_o), .data_i(tx_line_data_o),
        .ready_o(tx_line_ready_i), .got_o(got), .got_data_o(got_data));
    always #50 clk_i = ~clk_i;
    always @(negedge clk_i) rx_host_ready_i <= stall == 2'h0 || $urandom_range(1) != 0;
    function automatic [7:0] pick();
        pick = ($urandom_range(3) == 0) ? picks[$urandom_range(5)] : $urandom;
    endfunction
    task automatic tx_model(input [7:0] c);
        reg [7:0] q[$];
        reg [7:0] v;
        if (translation_option_word_i[5]) q.push_back(c);
        else if (c == `CTP_HOST_LINE_END_CODE) begin
            q.push_back(`CTP_CR_CODE);
            if (translation_option_word_i[6]) q.push_back(`CTP_LF_CODE);
        end else if (!(translation_option_word_i[4] && (c < 8'h20 || c > 8'h7C))) q.push_back(c & 8'h7F);
        foreach (q[k]) begin
            v = q[k];
            // Odd and even differ only in the inverted reduction
            if (translation_option_word_i[1:0] != 2'h0) v[7] = translation_option_word_i[1:0] == 2'h3 ||
                (^v[6:0] ^ !translation_option_word_i[1]);
            exp_tx.push_back({1'b0, v & (8'hFF >> word_size_i)});
        end
    endtask
    task automatic rx_model(input [7:0] c);
        reg [7:0] v;
        reg [1:0] p;
        p = translation_option_word_i[3:2];
        v = c | ~(8'hFF >> word_size_i);
        if ((p == 2'h1 && !(^v)) || (p == 2'h2 && ^v)) exp_perr = 1'b1;
        if (p != 2'h0) v[7] = 1'b0;
        if (!translation_option_word_i[5]) begin
            v[7] = 1'b0;
            if (v == `CTP_CR_CODE) v = `CTP_HOST_LINE_END_CODE;
            else if (translation_option_word_i[4] && (v < 8'h20 || v > 8'h7C)) v = substitute_char_value_i;
        end
        exp_rx.push_back({1'b0, v});
    endtask
    task automatic send(input bit rx, input [7:0] c);
        int k;
        @(negedge clk_i);
        if (rx) begin
            rx_line_valid_i = 1'b1;
            rx_line_data_i = c;
        end else begin
            tx_host_valid_i = 1'b1;
            tx_host_data_i = c;
        end
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while ((rx ? rx_line_ready_o : tx_host_ready_o) !== 1'b1 && k < 300);
        if ((rx ? rx_line_ready_o : tx_host_ready_o) !== 1'b1) begin
            err_count++;
            finish_test;
        end
        if (rx) rx_model(c);
        else tx_model(c);
    endtask
    task automatic load(input [6:0] o, input [1:0] w, input [1:0] s);
        @(negedge clk_i);
        translation_option_word_i = o;
        word_size_i = w;
        substitute_char_value_i = $urandom;
        stall = s;
        cfg_load_i = 1'b1;
        @(negedge clk_i);
        cfg_load_i = 1'b0;
        `CHK("xlat_mode_o", o[5] ? 2'h2 : {1'b0, o[4]}, xlat_mode_o)
        `CHK("append_lf_o", o[6] && !o[5], append_lf_o)
    endtask
    task automatic drain();
        int k;
        for (k = 0; k < 3000 && exp_tx.size() + exp_rx.size() > 0; k++) @(posedge clk_i);
        if (exp_tx.size() + exp_rx.size() > 0) begin
            err_count++;
            finish_test;
        end
        repeat (3) @(negedge clk_i);
        `CHK("tx_line_valid_o", 1'b0, tx_line_valid_o)
        `CHK("par_err_o", exp_perr, par_err_o)
        par_err_clr_i = 1'b1;
        @(negedge clk_i);
        par_err_clr_i = 1'b0;
        exp_perr = 1'b0;
        `CHK("par_err_o", 1'b0, par_err_o)
    endtask
    task finish_test;
        if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk_i) begin
        if (got) begin
            e = exp_tx.size() != 0 ? exp_tx.pop_front() : 9'h100;
            `CHK("tx_line_data_o", e, {1'b0, got_data})
        end
        if (rx_host_valid_o && rx_host_ready_i) begin
            e = exp_rx.size() != 0 ? exp_rx.pop_front() : 9'h100;
            `CHK("rx_host_data_o", e, {1'b0, rx_host_data_o})
        end
    end
    initial begin
        void'($urandom(48281));
        repeat (12) @(posedge clk_i);
        @(negedge clk_i);
        rst_b_i = 1'b1;
        `CHK("xlat_mode_o", 2'h0, xlat_mode_o)
        `CHK("append_lf_o", 1'b0, append_lf_o)
        // First pass runs on the reset configuration, parity untouched
        for (i = -1; i < 16; i++) begin
            if (i >= 0) load({i[0] ^ i[3], i[1:0] ^ i[3:2], i[3:2], i[1:0]}, i[0] ? i[3:2] : 2'h0, {1'b0, i[1]});
            fork
                begin
                    for (a = 0; a < 40; a++) send(1'b0, pick());
                    @(negedge clk_i);
                    tx_host_valid_i = 1'b0;
                    tx_host_data_i = ~tx_host_data_i;
                end
                begin
                    for (b = 0; b < 40; b++) send(1'b1, pick());
                    @(negedge clk_i);
                    rx_line_valid_i = 1'b0;
                    rx_line_data_i = ~rx_line_data_i;
                end
            join
            drain();
        end
        // Far side holds off until the buffer refuses, then drains it
        load(7'h20, 2'h0, 2'h2);
        repeat (4) send(1'b0, 8'h41);
        @(negedge clk_i);
        tx_host_valid_i = 1'b0;
        `CHK("tx_host_ready_o", 1'b0, tx_host_ready_o)
        stall = 2'h0;
        drain();
        finish_test;
    end
endmodule
